// file: sfr_read_engine.v
/*
  read command engine of a serial nor flash: opcode decode, address,
  dummy and data phases for single, fast, dual and quad reads in spi mode,
  and fast and quad reads in four-line command mode, plus the wide-address exit.
  assumes chip select, serial clock and data lines come from pins and
  are slower than CORE_CLK by a good margin (at least 8 core clocks per
  serial clock); config inputs come from logic on CORE_CLK.
*/
// Functional notes
// - exit command clears wide flag, 24-bit afterwards
// - address sampled rising, data driven falling
// - address increments per byte, wraps to zero
// - 3-byte address unless wide, extended bit upper
// - basic read: opcode, address, stream until deselect
// - reads ignored while internal write cycle busy
// - fast read: 8 dummies, single-line data
// - four-line fast read: 2-clock opcode, 4 dummies
// - dual-output read: 8 dummies, two-bit data
// - dual-io read: two-bit address, 4 dummies default
// - dummy select bits set configurable counts
// - quad-output read: 8 dummies, four-bit data
// - quad-io read: four-bit phases, 6 dummies default
// - quad-io read also accepted in four-line mode
// - short-dummy quad-io read: 4 dummies, quad data
// - wide mode lengthens address to four bytes
// - dummy select maps to per-command clock counts
`timescale 1ns/1ps
`include "sfr_map.vh"
module sfr_read_engine #(
  parameter ARRAY_AW = `SFR_ARRAY_AW
) (
  input  wire                CORE_CLK,
  input  wire                RESET,
  input  wire                CLK_EN,
  input  wire                CS_N,
  input  wire                SCLK,
  input  wire [3:0]          SIO_IN,
  output reg  [3:0]          SIO_OUT,
  output reg  [3:0]          SIO_OE_N,
  input  wire                WRITE_BUSY,
  input  wire                FOUR_LINE_MODE,
  input  wire                QUAD_PERMIT,
  input  wire [1:0]          DUMMY_SEL,
  input  wire                EXT_ADDR_BIT,
  input  wire                WIDE_ADDR_SET,
  output reg                 WIDE_ADDR_FLAG,
  output reg                 READ_ACTIVE,
  output reg                 CMD_REJECTED,
  input  wire                LOAD_EN,
  input  wire [ARRAY_AW-1:0] LOAD_ADDR,
  input  wire [7:0]          LOAD_DATA
);

  // states
  localparam [2:0] ST_OP     = 3'h0;   // shifting opcode
  localparam [2:0] ST_ADDR   = 3'h1;   // shifting address
  localparam [2:0] ST_DUMMY  = 3'h2;   // dummy / mode clocks
  localparam [2:0] ST_DATA   = 3'h3;   // streaming data out
  localparam [2:0] ST_IGNORE = 3'h4;   // wait for deselect
  localparam [2:0] ST_EXIT   = 3'h5;   // exit opcode seen

  // pin synchronisers
  reg  [1:0]          cs_s;            // chip select, two stages
  reg  [1:0]          sck_s;           // serial clock, two stages
  reg                 sck_d;           // delayed copy for edges
  reg  [3:0]          sio_s1;          // data lines, first stage
  reg  [3:0]          sio_s2;          // data lines, second stage

  // engine state
  reg  [2:0]          state;           // phase of the command
  reg  [5:0]          cnt;             // serial clocks in phase
  reg  [7:0]          opc;             // opcode shift register
  reg  [31:0]         addr;            // address shift register
  reg  [1:0]          alg;             // address lanes code
  reg  [1:0]          dlg;             // data lanes code
  reg  [3:0]          dum;             // dummy clocks of command
  reg                 wide_cmd;        // address width latched
  reg  [2:0]          bpos;            // data clock within byte
  reg  [7:0]          obyte;           // byte being shifted out
  reg  [ARRAY_AW-1:0] rd_addr;         // next byte to fetch
  wire [7:0]          mem_q;           // fetched byte

  // edge and level decodes from settled stages only
  wire                cs_high = cs_s[1];
  wire                rise    = sck_s[1] & ~sck_d;
  wire                fall    = ~sck_s[1] & sck_d;

  // phase lengths
  wire [5:0]          op_last   = (FOUR_LINE_MODE ? `SFR_OP_CLKS_QPI : `SFR_OP_CLKS_SPI) - 6'h01;
  wire [5:0]          addr_bits = wide_cmd ? `SFR_ADDR_BITS_WIDE : `SFR_ADDR_BITS_STD;
  wire [5:0]          addr_last = (addr_bits >> alg) - 6'h01;
  wire [5:0]          dum_last  = {2'h0, dum} - 6'h01;
  wire [2:0]          byte_last = 3'h7 >> dlg;

  // shift lanes into a register, msb first; single line reads sio0
  function [31:0] shift_in;
    input [31:0] v;
    input [1:0]  lg;
    input [3:0]  s;
    begin
      case (lg)
        `SFR_LG1: shift_in = {v[30:0], s[0]};
        `SFR_LG2: shift_in = {v[29:0], s[1:0]};
        default:  shift_in = {v[27:0], s[3:0]};
      endcase
    end
  endfunction

  // top bits of a byte onto the lanes; single line drives sio1
  function [3:0] lane_out;
    input [7:0] b;
    input [1:0] lg;
    begin
      case (lg)
        `SFR_LG1: lane_out = {2'h0, b[7], 1'b0};
        `SFR_LG2: lane_out = {2'h0, b[7:6]};
        default:  lane_out = b[7:4];
      endcase
    end
  endfunction

  // enables of driven lanes, low means driven
  function [3:0] lane_oe_n;
    input [1:0] lg;
    begin
      case (lg)
        `SFR_LG1: lane_oe_n = 4'hD;
        `SFR_LG2: lane_oe_n = 4'hC;
        default:  lane_oe_n = 4'h0;
      endcase
    end
  endfunction

  // remaining bits after one data clock
  function [7:0] lane_shift;
    input [7:0] b;
    input [1:0] lg;
    begin
      case (lg)
        `SFR_LG1: lane_shift = {b[6:0], 1'b0};
        `SFR_LG2: lane_shift = {b[5:0], 2'h0};
        default:  lane_shift = {b[3:0], 4'h0};
      endcase
    end
  endfunction

  // decode of a complete opcode
  reg                 next_ok;         // accepted read
  reg                 next_exit;       // wide-address exit
  reg  [1:0]          next_alg;        // address lanes
  reg  [1:0]          next_dlg;        // data lanes
  reg  [3:0]          next_dum;        // dummy clocks
  reg  [7:0]          next_op;         // full opcode value
  reg  [31:0]         op_word;         // opcode shifter, upper bits unused
  reg                 quad_ok;         // quad lanes allowed

  always @* begin
    op_word   = shift_in({24'h000000, opc}, FOUR_LINE_MODE ? `SFR_LG4 : `SFR_LG1, sio_s2);
    next_op   = op_word[7:0];
    next_ok   = 1'b0;
    next_exit = 1'b0;
    next_alg  = `SFR_LG1;
    next_dlg  = `SFR_LG1;
    next_dum  = `SFR_DUM_NONE;
    quad_ok   = QUAD_PERMIT | FOUR_LINE_MODE;
    if (FOUR_LINE_MODE) begin
      // four-line mode: only quad-lane reads and the exit
      case (next_op)
        `SFR_OP_FAST: begin
          next_ok = 1'b1;
          next_alg = `SFR_LG4;
          next_dlg = `SFR_LG4;
          next_dum = `SFR_DUM_4;
        end
        `SFR_OP_QUAD_IO: begin
          next_ok = 1'b1;
          next_alg = `SFR_LG4;
          next_dlg = `SFR_LG4;
        end
        `SFR_OP_QUAD_IO_SD: begin
          next_ok = 1'b1;
          next_alg = `SFR_LG4;
          next_dlg = `SFR_LG4;
          next_dum = `SFR_DUM_4;
        end
        `SFR_OP_EXIT_WIDE: next_exit = 1'b1;
        default: next_ok = 1'b0;
      endcase
    end else begin
      case (next_op)
        `SFR_OP_READ: next_ok = 1'b1;
        `SFR_OP_FAST: begin
          next_ok = 1'b1;
          next_dum = `SFR_DUM_8;
        end
        `SFR_OP_DUAL_OUT: begin
          next_ok = 1'b1;
          next_dlg = `SFR_LG2;
          next_dum = `SFR_DUM_8;
        end
        `SFR_OP_DUAL_IO: begin
          next_ok = 1'b1;
          next_alg = `SFR_LG2;
          next_dlg = `SFR_LG2;
        end
        `SFR_OP_QUAD_OUT: begin
          next_ok = quad_ok;
          next_dlg = `SFR_LG4;
          next_dum = `SFR_DUM_8;
        end
        `SFR_OP_QUAD_IO: begin
          next_ok = quad_ok;
          next_alg = `SFR_LG4;
          next_dlg = `SFR_LG4;
        end
        `SFR_OP_QUAD_IO_SD: begin
          next_ok = quad_ok;
          next_alg = `SFR_LG4;
          next_dlg = `SFR_LG4;
          next_dum = `SFR_DUM_4;
        end
        `SFR_OP_EXIT_WIDE: next_exit = 1'b1;
        default: next_ok = 1'b0;
      endcase
    end
    // configurable counts follow the dummy select field
    if (next_op == `SFR_OP_QUAD_IO) begin
      case (DUMMY_SEL)
        2'h0: next_dum = `SFR_DUM_6;
        2'h1: next_dum = `SFR_DUM_4;
        2'h2: next_dum = `SFR_DUM_8;
        default: next_dum = `SFR_DUM_10;
      endcase
    end
    if (next_op == `SFR_OP_DUAL_IO && !FOUR_LINE_MODE) begin
      next_dum = DUMMY_SEL[0] ? `SFR_DUM_8 : `SFR_DUM_4;
    end
    // busy internal cycle: reads refused, running cycle untouched
    if (WRITE_BUSY) begin
      next_ok = 1'b0;
    end
  end

  // composed array address; upper byte only in wide mode
  wire [31:0]         new_addr  = shift_in(addr, alg, sio_s2);
  wire [31:0]         full_addr = wide_cmd ? new_addr : {7'h00, EXT_ADDR_BIT, new_addr[23:0]};

  // two-stage capture of every pin before use
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      cs_s   <= 2'h3;
      sck_s  <= 2'h0;
      sck_d  <= 1'b0;
      sio_s1 <= 4'h0;
      sio_s2 <= 4'h0;
    end else if (CLK_EN) begin
      cs_s   <= {cs_s[0], CS_N};
      sck_s  <= {sck_s[0], SCLK};
      sck_d  <= sck_s[1];
      sio_s1 <= SIO_IN;
      sio_s2 <= sio_s1;
    end
  end

  // wide flag: set input wins over a clear in the same cycle
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      WIDE_ADDR_FLAG <= 1'b0;
    end else if (CLK_EN) begin
      if (WIDE_ADDR_SET) begin
        WIDE_ADDR_FLAG <= 1'b1;
      end else if (cs_high && state == ST_EXIT) begin
        WIDE_ADDR_FLAG <= 1'b0;
      end
    end
  end

  // command sequencer, advanced on settled serial clock edges
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state        <= ST_OP;
      cnt          <= 6'h00;
      opc          <= 8'h00;
      addr         <= 32'h00000000;
      alg          <= `SFR_LG1;
      dlg          <= `SFR_LG1;
      dum          <= `SFR_DUM_NONE;
      wide_cmd     <= 1'b0;
      bpos         <= 3'h0;
      obyte        <= 8'h00;
      rd_addr      <= {ARRAY_AW{1'b0}};
      SIO_OUT      <= 4'h0;
      SIO_OE_N     <= 4'hF;
      READ_ACTIVE  <= 1'b0;
      CMD_REJECTED <= 1'b0;
    end else if (CLK_EN) begin
      CMD_REJECTED <= 1'b0;
      READ_ACTIVE  <= (state == ST_DATA) & ~cs_high;
      if (cs_high) begin
        // deselect ends any phase and releases the lines
        state    <= ST_OP;
        cnt      <= 6'h00;
        bpos     <= 3'h0;
        SIO_OE_N <= 4'hF;
        SIO_OUT  <= 4'h0;
      end else begin
        case (state)
          ST_OP: begin
            if (rise) begin
              opc <= next_op;
              cnt <= cnt + 6'h01;
              if (cnt == op_last) begin
                cnt      <= 6'h00;
                addr     <= 32'h00000000;
                alg      <= next_alg;
                dlg      <= next_dlg;
                dum      <= next_dum;
                wide_cmd <= WIDE_ADDR_FLAG;
                if (next_exit) begin
                  state <= ST_EXIT;
                end else if (next_ok) begin
                  state <= ST_ADDR;
                end else begin
                  state        <= ST_IGNORE;
                  CMD_REJECTED <= 1'b1;
                end
              end
            end
          end
          ST_ADDR: begin
            // address bits taken on rising edges only
            if (rise) begin
              addr <= new_addr;
              cnt  <= cnt + 6'h01;
              if (cnt == addr_last) begin
                cnt     <= 6'h00;
                rd_addr <= full_addr[ARRAY_AW-1:0];
                state   <= (dum == `SFR_DUM_NONE) ? ST_DATA : ST_DUMMY;
              end
            end
          end
          ST_DUMMY: begin
            // lines stay released: the host may drive mode bits here
            if (rise) begin
              cnt <= cnt + 6'h01;
              if (cnt == dum_last) begin
                cnt   <= 6'h00;
                state <= ST_DATA;
              end
            end
          end
          ST_DATA: begin
            // data driven on falling edges, host samples on rising
            if (fall) begin
              SIO_OE_N <= lane_oe_n(dlg);
              bpos     <= (bpos == byte_last) ? 3'h0 : bpos + 3'h1;
              if (bpos == 3'h0) begin
                SIO_OUT <= lane_out(mem_q, dlg);
                obyte   <= lane_shift(mem_q, dlg);
                rd_addr <= rd_addr + {{(ARRAY_AW-1){1'b0}}, 1'b1};
              end else begin
                SIO_OUT <= lane_out(obyte, dlg);
                obyte   <= lane_shift(obyte, dlg);
              end
            end
          end
          ST_EXIT: begin
            // any clock after the exit opcode spoils the sequence
            if (rise) begin
              state <= ST_IGNORE;
            end
          end
          ST_IGNORE: state <= ST_IGNORE;
          default: state <= ST_IGNORE;
        endcase
      end
    end
  end

  // byte array; fetch latency of one core clock is well inside
  // the two or more serial clocks between byte boundaries
  sfr_mem #(
    .DW (8),
    .AW (ARRAY_AW)
  ) u_mem (
    .clk   (CORE_CLK),
    .ce    (CLK_EN),
    .we    (LOAD_EN),
    .waddr (LOAD_ADDR),
    .wdata (LOAD_DATA),
    .raddr (rd_addr),
    .rdata (mem_q)
  );

endmodule // sfr_read_engine

// file: sfr_map.vh
/*
  constants of the serial flash read command engine: opcodes,
  dummy counts, lane codes, configuration bit positions.
  assumes it is included by bare name from the design files.
*/
`ifndef SFR_MAP_VH
`define SFR_MAP_VH

// opcodes of the read family and the wide-address exit
`define SFR_OP_READ        8'h03
`define SFR_OP_FAST        8'h0B
`define SFR_OP_DUAL_OUT    8'h3B
`define SFR_OP_DUAL_IO     8'hBB
`define SFR_OP_QUAD_OUT    8'h6B
`define SFR_OP_QUAD_IO     8'hEB
`define SFR_OP_QUAD_IO_SD  8'hE7
`define SFR_OP_EXIT_WIDE   8'hE9

// configuration register bit positions
`define SFR_CFG_WIDE_BIT   5
`define SFR_CFG_DSEL_LO    6
`define SFR_CFG_DSEL_HI    7

// lane codes: log2 of lines per clock
`define SFR_LG1            2'h0
`define SFR_LG2            2'h1
`define SFR_LG4            2'h2

// dummy clock counts
`define SFR_DUM_NONE       4'h0
`define SFR_DUM_4          4'h4
`define SFR_DUM_6          4'h6
`define SFR_DUM_8          4'h8
`define SFR_DUM_10         4'hA

// phase lengths: opcode in serial clocks, address in bits
`define SFR_OP_CLKS_SPI    6'h08
`define SFR_OP_CLKS_QPI    6'h02
`define SFR_ADDR_BITS_STD  6'h18
`define SFR_ADDR_BITS_WIDE 6'h20

// default array address width (bytes = 2**aw)
`define SFR_ARRAY_AW       8

`endif

// file: sfr_mem.v
/*
  byte-wide array model: one write port, one read port whose data
  come out of a register one core clock after the address.
  assumes a single clock domain and an active-high clock enable.
*/
`timescale 1ns/1ps
module sfr_mem #(
  parameter DW = 8,
  parameter AW = 8
) (
  input  wire          clk,
  input  wire          ce,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];   // storage, no reset on purpose

  // write and registered read; read-during-write gives old data
  always @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end

endmodule // sfr_mem

// file: sfr_read_engine_checker.sv
/*
  port assertions for the read engine.
  assumes a bind onto sfr_read_engine; one core clock domain.
*/
`timescale 1ns/1ps
module sfr_read_engine_checker (
  input logic       CORE_CLK,
  input logic       RESET,
  input logic       CS_N,
  input logic [3:0] SIO_OE_N,
  input logic       WRITE_BUSY,
  input logic       FOUR_LINE_MODE,
  input logic       QUAD_PERMIT,
  input logic       WIDE_ADDR_SET,
  input logic       WIDE_ADDR_FLAG,
  input logic       READ_ACTIVE,
  input logic       CMD_REJECTED
);
  // single domain, so clock and reset are given once
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  property p_idle;
    CS_N [*8] |-> SIO_OE_N == 4'hF && !READ_ACTIVE;
  endproperty
  a_idle: assert property (p_idle) else $error("lines driven while deselected");
  property p_release;
    $rose(CS_N) |-> ##[1:6] (SIO_OE_N == 4'hF && !READ_ACTIVE);
  endproperty
  a_release: assert property (p_release) else $error("lines kept after deselect");
  property p_rej_quiet;
    CMD_REJECTED |-> SIO_OE_N == 4'hF && !READ_ACTIVE;
  endproperty
  a_rej_quiet: assert property (p_rej_quiet) else $error("refused read drives lines");
  property p_rej_pulse;
    CMD_REJECTED |=> !CMD_REJECTED;
  endproperty
  a_rej_pulse: assert property (p_rej_pulse) else $error("refusal pulse too long");
  property p_act_busy;
    $rose(READ_ACTIVE) |-> !WRITE_BUSY;
  endproperty
  a_act_busy: assert property (p_act_busy) else $error("read ran while busy");
  property p_exit;
    $fell(WIDE_ADDR_FLAG) |-> CS_N && !WIDE_ADDR_SET;
  endproperty
  a_exit: assert property (p_exit) else $error("wide flag cleared inside a frame");
  property p_set;
    WIDE_ADDR_SET |-> ##[1:2] WIDE_ADDR_FLAG;
  endproperty
  a_set: assert property (p_set) else $error("wide flag not set");
  property p_quad;
    SIO_OE_N == 4'h0 |-> QUAD_PERMIT || FOUR_LINE_MODE;
  endproperty
  a_quad: assert property (p_quad) else $error("quad drive without permit");
  property p_four;
    FOUR_LINE_MODE && SIO_OE_N != 4'hF |-> SIO_OE_N == 4'h0;
  endproperty
  a_four: assert property (p_four) else $error("narrow lanes in four-line mode");
  property p_rst;
    $fell(RESET) |-> SIO_OE_N == 4'hF && !WIDE_ADDR_FLAG && !READ_ACTIVE;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
endmodule // sfr_read_engine_checker

bind sfr_read_engine sfr_read_engine_checker u_chk (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .CS_N(CS_N), .SIO_OE_N(SIO_OE_N),
  .WRITE_BUSY(WRITE_BUSY), .FOUR_LINE_MODE(FOUR_LINE_MODE), .QUAD_PERMIT(QUAD_PERMIT),
  .WIDE_ADDR_SET(WIDE_ADDR_SET), .WIDE_ADDR_FLAG(WIDE_ADDR_FLAG),
  .READ_ACTIVE(READ_ACTIVE), .CMD_REJECTED(CMD_REJECTED)
);

// file: sfr_host_model.sv
/*
  host controller model: frames opcode, address, dummies, data.
  assumes clk is the core clock; a serial clock is 8 core clocks.
*/
`timescale 1ns/1ps
module sfr_host_model (
  input  logic       clk,
  input  logic [3:0] sio_out,
  input  logic [3:0] sio_oe_n,
  output logic       cs_n,
  output logic       sclk,
  output logic [3:0] sio_in
);
  logic [3:0] hval;    // host line values
  logic [3:0] hdrv;    // host drive enables
  logic [3:0] tog;     // floating lines must not look stable
  logic [3:0] oe_and;  // enables seen at every sample
  logic [3:0] oe_or;
  logic [7:0] q[$];    // bytes read back

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;  // serial clock parked low outside frames
    hval = 4'h0;
    hdrv = 4'h0;
    tog  = 4'h5;
  end
  always @(posedge clk) tog <= ~tog;
  // wire level: device, then host, else a changing pattern
  assign sio_in = (~sio_oe_n & sio_out) | (sio_oe_n & hdrv & hval) | (sio_oe_n & ~hdrv & tog);

  function automatic logic [3:0] lanes(input logic [1:0] lg);
    return lg == 2'h0 ? 4'h1 : lg == 2'h1 ? 4'h3 : 4'hF;
  endfunction
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // one serial clock: lines change at the fall, device samples at the rise
  task automatic tick(input logic [3:0] v, input logic [3:0] d);
    sclk = 1'b0;
    hval = v;
    hdrv = d;
    half();
    sclk = 1'b1;
    half();
  endtask
  task automatic shift(input logic [31:0] v, input int bits, input logic [1:0] lg);
    int n;
    n = 1 << lg;
    for (int i = bits - n; i >= 0; i -= n) tick(4'(v >> i) & lanes(lg), lanes(lg));
  endtask
  task automatic run(input logic [7:0] op, input logic [1:0] ol, input logic [31:0] a, input int ab,
                     input logic [1:0] al, input int dum, input logic [1:0] dl, input int nb);
    logic [7:0] b;
    int         n;
    q.delete();
    oe_and = 4'hF;
    oe_or  = 4'h0;
    b      = 8'h00;
    n      = 1 << dl;
    cs_n   = 1'b0;
    half();
    shift(op, 8, ol);
    shift(a, ab, al);
    // mode clocks stay driven, the rest are turned around
    for (int k = 0; k < dum; k++) tick(4'h0, k < 2 ? lanes(al) : 4'h0);
    for (int i = 0; i < nb; i++) begin
      for (int j = 0; j < 8; j += n) begin
        tick(4'h0, 4'h0);
        b = (b << n) | (dl == 2'h0 ? {3'h0, sio_in[1]} : sio_in & lanes(dl));
        oe_and = oe_and & sio_oe_n;
        oe_or  = oe_or | sio_oe_n;
      end
      q.push_back(b);
    end
    sclk = 1'b0;  // clock low before chip select moves
    half();
    cs_n = 1'b1;
    hdrv = 4'h0;
    half();
    half();
  endtask
endmodule // sfr_host_model

// file: tb_serial_flash_read_command_engine.sv
/*
  self-checking bench of the read engine against a reference model.
  assumes sfr_host_model as host and the checker bound to the design.
*/
`timescale 1ns/1ps
`include "sfr_map.vh"
module tb_serial_flash_read_command_engine;
  localparam int AW = 8;
  logic          CORE_CLK, RESET, CLK_EN, CS_N, SCLK, WRITE_BUSY, FOUR_LINE_MODE, QUAD_PERMIT;
  logic          EXT_ADDR_BIT, WIDE_ADDR_SET, WIDE_ADDR_FLAG, READ_ACTIVE, CMD_REJECTED, LOAD_EN;
  logic [3:0]    SIO_IN, SIO_OUT, SIO_OE_N;
  logic [1:0]    DUMMY_SEL;
  logic [AW-1:0] LOAD_ADDR;
  logic [7:0]    LOAD_DATA;
  int            error_cnt, tests_run, cycles, rej_cnt, act_cnt, wide;
  int            mem [0:255];                   // reference array
  int            qd [4] = '{6, 4, 8, 10};       // quad-io dummies per select
  logic [7:0]    ops [7] = '{`SFR_OP_READ, `SFR_OP_FAST, `SFR_OP_DUAL_OUT, `SFR_OP_DUAL_IO,
                             `SFR_OP_QUAD_OUT, `SFR_OP_QUAD_IO, `SFR_OP_QUAD_IO_SD};

  sfr_read_engine #(.ARRAY_AW(AW)) uut (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .CLK_EN(CLK_EN), .CS_N(CS_N), .SCLK(SCLK),
    .SIO_IN(SIO_IN), .SIO_OUT(SIO_OUT), .SIO_OE_N(SIO_OE_N), .WRITE_BUSY(WRITE_BUSY),
    .FOUR_LINE_MODE(FOUR_LINE_MODE), .QUAD_PERMIT(QUAD_PERMIT), .DUMMY_SEL(DUMMY_SEL),
    .EXT_ADDR_BIT(EXT_ADDR_BIT), .WIDE_ADDR_SET(WIDE_ADDR_SET), .WIDE_ADDR_FLAG(WIDE_ADDR_FLAG),
    .READ_ACTIVE(READ_ACTIVE), .CMD_REJECTED(CMD_REJECTED), .LOAD_EN(LOAD_EN),
    .LOAD_ADDR(LOAD_ADDR), .LOAD_DATA(LOAD_DATA)
  );
  sfr_host_model host (
    .clk(CORE_CLK), .sio_out(SIO_OUT), .sio_oe_n(SIO_OE_N), .cs_n(CS_N), .sclk(SCLK), .sio_in(SIO_IN)
  );

  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  // refusal pulses and a cycle ceiling against hangs
  always @(posedge CORE_CLK) begin
    cycles++;
    if (CMD_REJECTED === 1'b1) rej_cnt++;
    if (READ_ACTIVE === 1'b1) act_cnt++;
    if (cycles == 90000) begin
      error_cnt++;
      $display("[ERR] %0t run did not finish", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // reference read: lanes, dummies and refusal follow the command rules
  task automatic rd(input logic [7:0] op, input int nb);
    logic [31:0] a;
    logic [1:0]  ol, al, dl;
    logic [3:0]  m;
    int          dum, r0, a0;
    logic        rej, fl;
    a   = $urandom;
    fl  = FOUR_LINE_MODE;
    ol  = fl ? 2'h2 : 2'h0;
    al  = ol;
    dl  = 2'h0;
    dum = 0;
    rej = WRITE_BUSY;
    if (a[8]) a[7:2] = 6'h3F;  // start near the top so the stream wraps
    case (op)
      `SFR_OP_READ:       rej = rej | fl;
      `SFR_OP_FAST:       {dl, dum} = {al, fl ? 32'd4 : 32'd8};
      `SFR_OP_DUAL_OUT:   {rej, dl, dum} = {rej | fl, 2'h1, 32'd8};
      `SFR_OP_DUAL_IO:    {rej, al, dl, dum} = {rej | fl, 4'h5, DUMMY_SEL[0] ? 32'd8 : 32'd4};
      `SFR_OP_QUAD_OUT:   {rej, dl, dum} = {rej | fl | !QUAD_PERMIT, 2'h2, 32'd8};
      `SFR_OP_QUAD_IO:    {rej, al, dl, dum} = {rej | (!fl & !QUAD_PERMIT), 4'hA, qd[DUMMY_SEL]};
      `SFR_OP_QUAD_IO_SD: {rej, al, dl, dum} = {rej | (!fl & !QUAD_PERMIT), 4'hA, 32'd4};
      default:            rej = 1'b1;
    endcase
    m  = dl == 2'h0 ? 4'hD : dl == 2'h1 ? 4'hC : 4'h0;
    r0 = rej_cnt;
    a0 = act_cnt;
    if (rej) host.run(op, ol, a, 0, al, 0, 2'h0, 1);
    else host.run(op, ol, a, wide ? 32 : 24, al, dum, dl, nb);
    chk(rej_cnt - r0, rej, "refusals");
    chk(act_cnt > a0, !rej, "data phase flag");
    chk(host.oe_and, rej ? 4'hF : m, "lane enables");
    chk(host.oe_or, rej ? 4'hF : m, "lane enables held");
    if (!rej) chk(host.q.size(), nb, "byte count");
    for (int k = 0; k < host.q.size() && !rej; k++) chk(host.q[k], mem[(a + k) & 255], "data");
  endtask
  task end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    {RESET, WRITE_BUSY, FOUR_LINE_MODE, QUAD_PERMIT, EXT_ADDR_BIT} = 5'h13;
    CLK_EN = 1'b1;
    {WIDE_ADDR_SET, LOAD_EN, DUMMY_SEL, LOAD_ADDR, LOAD_DATA} = 20'h00000;
    void'($urandom(3735));
    repeat (6) @(posedge CORE_CLK);
    #1;
    RESET = 1'b0;
    // preload array and reference together
    for (int i = 0; i < 256; i++) begin
      {LOAD_EN, LOAD_ADDR, LOAD_DATA} = {1'b1, i[7:0], 8'($urandom)};
      mem[i] = LOAD_DATA;
      @(posedge CORE_CLK);
      #1;
    end
    LOAD_EN = 1'b0;
    for (int f = 0; f < 2; f++) begin
      for (int s = 0; s < 4; s++) begin
        FOUR_LINE_MODE = f[0];
        DUMMY_SEL      = s[1:0];
        EXT_ADDR_BIT   = $urandom;
        foreach (ops[i]) rd(ops[i], 5);
      end
    end
    $display("test read family done");
    FOUR_LINE_MODE = 1'b0;
    WIDE_ADDR_SET  = 1'b1;
    @(posedge CORE_CLK);
    #1;
    WIDE_ADDR_SET = 1'b0;
    wide = 1;
    chk(WIDE_ADDR_FLAG, 1'b1, "wide flag set");
    rd(`SFR_OP_READ, 2);
    rd(`SFR_OP_QUAD_IO, 2);
    host.run(`SFR_OP_EXIT_WIDE, 2'h0, 0, 0, 2'h0, 0, 2'h0, 0);
    wide = 0;
    chk(WIDE_ADDR_FLAG, 1'b0, "wide flag cleared");
    rd(`SFR_OP_DUAL_IO, 3);
    $display("test wide address done");
    QUAD_PERMIT = 1'b0;
    rd(`SFR_OP_QUAD_OUT, 1);
    rd(`SFR_OP_QUAD_IO, 1);
    QUAD_PERMIT = 1'b1;
    WRITE_BUSY  = 1'b1;
    foreach (ops[i]) rd(ops[i], 1);
    WRITE_BUSY = 1'b0;
    rd(8'h5A, 1);
    rd(`SFR_OP_READ, 2);
    $display("test refusals done");
    // frozen clock enable: a preload write must not land
    CLK_EN = 1'b0;
    {LOAD_EN, LOAD_ADDR, LOAD_DATA} = {1'b1, 8'h10, 8'(~mem[16])};
    repeat (3) @(posedge CORE_CLK);
    #1;
    {CLK_EN, LOAD_EN} = 2'h2;
    host.run(`SFR_OP_READ, 2'h0, 32'h10, 24, 2'h0, 0, 2'h0, 1);
    chk(host.q[0], mem[16], "frozen array");
    $display("test clock enable done");
    end_of_test();
  end
endmodule // tb_serial_flash_read_command_engine
